// *** byte_order_unit.sv ***
// byte lane ordering for loads and stores in either endianness
`timescale 1ns/1ns
`include "lsu_consts.svh"
module byte_order_unit (
  // lane data in and out
  lsu_if.ord_unit ord
);
  import lsu_pkg::*;
  logic [3:0] ld_nb;
  logic [3:0] st_nb;
  logic [3:0] ld_pos [`LSU_LANES];
  logic [3:0] st_rel [`LSU_LANES];
  logic [3:0] st_src [`LSU_LANES];
  logic [`LSU_LANES-1:0] st_in;

  // bytes per access from the size code
  assign ld_nb = 4'h1 << ord.ld_size;
  assign st_nb = 4'h1 << ord.st_size;

  ////////////////////////////////////////////////////////////////////////////
  // one lane per generate step: field byte i for loads, memory lane k for stores
  genvar gi;
  generate
    for (gi = 0; gi < `LSU_LANES; gi++) begin : g_lane
      // little: byte i from start+i; big: byte i from start+n-1-i
      assign ld_pos[gi] = (ord.big ? (ld_nb - 4'h1 - 4'(gi)) : 4'(gi)) + {1'b0, ord.ld_off};
      // bytes past n stay zero, so the result is never sign extended
      assign ord.ld_val[8*gi +: 8] = (4'(gi) < ld_nb) ? ord.ld_raw[8*ld_pos[gi][2:0] +: 8] : 8'h00;
      assign st_rel[gi] = 4'(gi) - {1'b0, ord.st_off};
      assign st_in[gi] = (4'(gi) >= {1'b0, ord.st_off}) && (st_rel[gi] < st_nb);
      assign st_src[gi] = ord.big ? (st_nb - 4'h1 - st_rel[gi]) : st_rel[gi];
      // only the low n bytes of the value can reach a lane
      assign ord.st_lanes[8*gi +: 8] = st_in[gi] ? ord.st_val[8*st_src[gi][2:0] +: 8] : 8'h00;
      assign ord.st_be[gi] = st_in[gi];
    end
  endgenerate
endmodule

// *** creg_check_unit.sv ***
// control register space decode and per register permission
`timescale 1ns/1ns
`include "lsu_consts.svh"
module creg_check_unit #(
  parameter int NUM_CREG = `LSU_CREG_NUM,
  parameter logic [63:0] USER_RD_MASK = `LSU_CREG_USER_RD_MASK,
  parameter logic [63:0] WR_MASK = `LSU_CREG_WR_MASK
) (
  // address in, verdict out
  lsu_if.creg_unit cr
);
  import lsu_pkg::*;
  localparam logic [31:0] BASE = `LSU_CREG_BASE;
  logic [`LSU_CREG_IDX_W-1:0] idx;
  logic defined;
  logic rd_ok;
  logic wr_ok;

  // decode of the space and of the register index
  assign cr.cr_is_space = cr.cr_addr[31:`LSU_CREG_SPACE_LSB] == BASE[31:`LSU_CREG_SPACE_LSB];
  assign idx = cr.cr_addr[`LSU_CREG_SPACE_LSB-1:2];
  // only whole words reach a control register; anything else counts as unmapped
  assign defined = (32'(idx) < 32'(NUM_CREG)) && (cr.cr_size == `LSU_SIZE_WORD);
  assign cr.cr_unmapped = cr.cr_is_space && !defined;
  // read and write rights are judged apart
  assign rd_ok = cr.cr_super || USER_RD_MASK[idx[5:0]];
  assign wr_ok = cr.cr_super && WR_MASK[idx[5:0]];
  assign cr.cr_perm_fault = cr.cr_is_space && defined && (cr.cr_write ? !wr_ok : !rd_ok);
endmodule

// *** load_store_access_check.sv ***
// checks, orders and issues the core's data memory accesses
`timescale 1ns/1ns
`include "lsu_consts.svh"
module load_store_access_check (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the pipeline
  input wire logic req_valid_i,
  input wire lsu_pkg::access_t req_kind_i,
  input wire lsu_pkg::size_t req_size_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [63:0] req_wdata_i,
  input wire logic bundle_fault_i,
  output logic req_ready_o,
  // status word bits
  input wire logic translation_on_i,
  input wire logic spec_load_align_trap_on_i,
  input wire logic dynamic_translation_on_i,
  input wire logic big_endian_i,
  input wire logic supervisor_i,
  // translation lookup result for req_addr_i
  input wire logic tlb_match_i,
  input wire logic tlb_multi_i,
  input wire logic tlb_read_ok_i,
  input wire logic tlb_write_ok_i,
  input wire logic [31:0] tlb_paddr_i,
  input wire logic system_control_unit_region_i,
  // data breakpoint range
  input wire logic dbreak_on_i,
  input wire logic [31:0] dbreak_lo_i,
  input wire logic [31:0] dbreak_hi_i,
  // memory request and response
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_creg_o,
  output logic [31:0] mem_paddr_o,
  output lsu_pkg::size_t mem_size_o,
  output logic [63:0] mem_wdata_o,
  output logic [7:0] mem_be_o,
  input wire logic mem_rvalid_i,
  input wire logic mem_rerr_i,
  input wire logic [63:0] mem_rdata_i,
  // load response to the pipeline
  output logic resp_valid_o,
  output logic [31:0] resp_data_o,
  // exceptions and hints
  output logic fault_valid_o,
  output lsu_pkg::fault_t fault_kind_o,
  output logic [31:0] fault_addr_o,
  output logic prefetch_o,
  output logic [31:0] prefetch_addr_o,
  output logic dbreak_hit_o
);
  import lsu_pkg::*;

  lsu_if lif();
  logic [2:0] nb_mask;
  logic misal;
  logic no_xlate;
  logic rd_viol;
  logic wr_viol;
  logic dis_zero;
  logic do_pref;
  logic accept;
  logic go;
  logic rsp_take;
  logic [31:0] paddr;
  fault_t next_fault;
  logic pend_valid;
  logic [31:0] pend_vaddr;
  size_t pend_size;
  logic [2:0] pend_off;
  logic next_pend;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  byte_order_unit u_order (.ord(lif.ord_unit));
  creg_check_unit u_creg (.cr(lif.creg_unit));

  // orderer: stores from the request, loads from the pending read
  assign lif.big = big_endian_i;
  assign lif.st_size = req_size_i;
  assign lif.st_off = paddr[2:0];
  assign lif.st_val = req_wdata_i;
  assign lif.ld_size = pend_size;
  assign lif.ld_off = pend_off;
  assign lif.ld_raw = mem_rdata_i;
  assign lif.cr_addr = req_addr_i;
  assign lif.cr_size = req_size_i;
  assign lif.cr_write = req_kind_i == ACC_STORE;
  assign lif.cr_super = supervisor_i;

  ////////////////////////////////////////////////////////////////////////////
  // address checks on the incoming request
  assign nb_mask = 3'((4'h1 << req_size_i) - 4'h1);
  assign misal = |(req_addr_i[2:0] & nb_mask);
  assign no_xlate = translation_on_i && !tlb_match_i;
  assign rd_viol = translation_on_i && !tlb_read_ok_i;
  assign wr_viol = translation_on_i && !tlb_write_ok_i;
  // control registers sit outside translation; dismissible loads always take the lookup path
  assign paddr = (lif.cr_is_space && req_kind_i != ACC_DIS_LOAD) ? req_addr_i : tlb_paddr_i;
  assign accept = req_valid_i && req_ready_o;
  // own fault or a sibling's fault keeps memory and registers untouched
  assign go = accept && !bundle_fault_i && (next_fault == FAULT_NONE);
  assign rsp_take = pend_valid && mem_rvalid_i;

  // fault selection per access kind; if-else order gives the priority
  always_comb begin
    next_fault = FAULT_NONE;
    dis_zero = 1'b0;
    do_pref = 1'b0;
    case (req_kind_i)
      ACC_LOAD: begin
        if (misal) begin
          next_fault = FAULT_MISALIGN;
        end else if (lif.cr_is_space) begin
          if (lif.cr_unmapped) begin
            next_fault = FAULT_CREG_UNMAPPED;
          end else if (lif.cr_perm_fault) begin
            next_fault = FAULT_CREG_PERM;
          end
        end else if (translation_on_i && (no_xlate || tlb_multi_i || rd_viol)) begin
          next_fault = FAULT_XLATE;
        end
      end
      ACC_DIS_LOAD: begin
        if (misal && spec_load_align_trap_on_i) begin
          next_fault = FAULT_MISALIGN;
        end else if (translation_on_i && (tlb_multi_i || (dynamic_translation_on_i && no_xlate))) begin
          next_fault = FAULT_XLATE;
        end
        dis_zero = misal || no_xlate || rd_viol || !system_control_unit_region_i;
      end
      ACC_PREFETCH: begin
        // a hint only: it never selects a fault
        do_pref = !no_xlate && !tlb_multi_i && !rd_viol && system_control_unit_region_i;
      end
      ACC_STORE: begin
        if (misal) begin
          next_fault = FAULT_MISALIGN;
        end else if (lif.cr_is_space) begin
          if (lif.cr_unmapped) begin
            next_fault = FAULT_CREG_UNMAPPED;
          end else if (lif.cr_perm_fault) begin
            next_fault = FAULT_CREG_PERM;
          end
        end else if (no_xlate || tlb_multi_i || wr_viol) begin
          next_fault = FAULT_XLATE;
        end
      end
      default: begin
        next_fault = FAULT_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // exception report: one cycle; a bus error can only arrive while nothing is accepted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_valid_o <= 1'b0;
      fault_kind_o <= FAULT_NONE;
      fault_addr_o <= 32'h00000000;
    end else if (rsp_take && mem_rerr_i) begin
      fault_valid_o <= 1'b1;
      fault_kind_o <= FAULT_BUS;
      fault_addr_o <= pend_vaddr;
    end else if (accept && next_fault != FAULT_NONE) begin
      fault_valid_o <= 1'b1;
      fault_kind_o <= next_fault;
      fault_addr_o <= req_addr_i;
    end else begin
      fault_valid_o <= 1'b0;
    end
  end

  // memory request issue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_creg_o <= 1'b0;
      mem_paddr_o <= 32'h00000000;
      mem_size_o <= 2'h0;
      mem_wdata_o <= 64'h0000000000000000;
      mem_be_o <= 8'h00;
    end else begin
      mem_req_o <= go && (req_kind_i == ACC_LOAD || req_kind_i == ACC_STORE ||
                          (req_kind_i == ACC_DIS_LOAD && !dis_zero));
      mem_we_o <= req_kind_i == ACC_STORE;
      mem_creg_o <= lif.cr_is_space && req_kind_i != ACC_DIS_LOAD;
      mem_paddr_o <= paddr;
      mem_size_o <= req_size_i;
      mem_wdata_o <= lif.st_lanes;
      mem_be_o <= (req_kind_i == ACC_STORE) ? lif.st_be : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single outstanding read: new requests wait, so a late answer cannot be mixed up
  always_comb begin
    next_pend = pend_valid;
    if (rsp_take) begin
      next_pend = 1'b0;
    end else if (go && (req_kind_i == ACC_LOAD || (req_kind_i == ACC_DIS_LOAD && !dis_zero))) begin
      next_pend = 1'b1;
    end
  end

  // pending read context
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_valid <= 1'b0;
      req_ready_o <= 1'b1;
      pend_vaddr <= 32'h00000000;
      pend_size <= 2'h0;
      pend_off <= 3'h0;
    end else begin
      pend_valid <= next_pend;
      req_ready_o <= !next_pend;
      if (go && !pend_valid) begin
        pend_vaddr <= req_addr_i;
        pend_size <= req_size_i;
        pend_off <= paddr[2:0];
      end
    end
  end

  // load response: zero for a dismissed read, else assembled bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resp_valid_o <= 1'b0;
      resp_data_o <= `LSU_RESP_ZERO;
    end else if (go && req_kind_i == ACC_DIS_LOAD && dis_zero) begin
      resp_valid_o <= 1'b1;
      resp_data_o <= `LSU_RESP_ZERO;
    end else if (rsp_take && !mem_rerr_i) begin
      resp_valid_o <= 1'b1;
      resp_data_o <= lif.ld_val[31:0];
    end else begin
      resp_valid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prefetch hint and data breakpoint flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prefetch_o <= 1'b0;
      prefetch_addr_o <= 32'h00000000;
      dbreak_hit_o <= 1'b0;
    end else begin
      prefetch_o <= accept && !bundle_fault_i && req_kind_i == ACC_PREFETCH && do_pref;
      prefetch_addr_o <= req_addr_i;
      dbreak_hit_o <= accept && req_kind_i != ACC_PREFETCH && dbreak_on_i &&
                      req_addr_i >= dbreak_lo_i && req_addr_i <= dbreak_hi_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the driven outputs
  AST_LOAD_MISALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_kind_i == ACC_LOAD && misal |=> fault_valid_o &&
    fault_kind_o == FAULT_MISALIGN && fault_addr_o == $past(req_addr_i) && !mem_req_o)
    else $error("misaligned load not trapped");
  AST_LOAD_XLATE: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_kind_i == ACC_LOAD && !misal && !lif.cr_is_space && translation_on_i &&
    tlb_multi_i |=> fault_valid_o && fault_kind_o == FAULT_XLATE)
    else $error("load translation fault missing");
  AST_DIS_NO_TRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_kind_i == ACC_DIS_LOAD && !spec_load_align_trap_on_i && !translation_on_i
    |=> !fault_valid_o)
    else $error("dismissible load faulted");
  AST_DIS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    go && req_kind_i == ACC_DIS_LOAD && misal |=> resp_valid_o && resp_data_o == 32'h0 &&
    !mem_req_o)
    else $error("dismissed load not zero");
  AST_BUS_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    rsp_take && mem_rerr_i |=> fault_valid_o && fault_kind_o == FAULT_BUS &&
    fault_addr_o == $past(pend_vaddr) && !resp_valid_o)
    else $error("bus read error lost");
  AST_PADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    go && !lif.cr_is_space && req_kind_i == ACC_STORE |=> mem_req_o &&
    mem_paddr_o == $past(tlb_paddr_i))
    else $error("store not at translated address");
  AST_ONE_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_req_o && !mem_we_o |-> !req_ready_o ##0 (pend_valid [*1]))
    else $error("read issued without pending context");
  AST_PREFETCH_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_kind_i == ACC_PREFETCH |=> !fault_valid_o && !mem_req_o)
    else $error("prefetch raised a fault");
  AST_STORE_BYTES: assert property (@(posedge clk_i) disable iff (rst_i)
    go && req_kind_i == ACC_STORE |=> mem_we_o && $countones(mem_be_o) == (1 << mem_size_o))
    else $error("store byte enables wrong");
  AST_BUNDLE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && bundle_fault_i |=> !mem_req_o && !resp_valid_o && !prefetch_o)
    else $error("faulted bundle updated state");
  AST_CREG_WORD: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && req_kind_i == ACC_LOAD && lif.cr_is_space && !misal && req_size_i != 2'h2
    |=> fault_valid_o && fault_kind_o == FAULT_CREG_UNMAPPED)
    else $error("non-word control register access passed");
endmodule

// *** lsu_consts.svh ***
// constants for the load/store access checker
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH
`define LSU_ADDR_W 32
`define LSU_DATA_W 64
`define LSU_RESP_W 32
`define LSU_LANES 8
`define LSU_CREG_BASE 32'hffff0000
`define LSU_CREG_SPACE_LSB 16
`define LSU_CREG_NUM 64
`define LSU_CREG_IDX_W 14
`define LSU_CREG_USER_RD_MASK 64'hffffffffffffffff
`define LSU_CREG_WR_MASK 64'hffffffffffffffff
`define LSU_SIZE_WORD 2'h2
`define LSU_RESP_ZERO 32'h00000000
`endif

// *** lsu_if.sv ***
// carrier between the checker and its byte orderer and control register decoder
`timescale 1ns/1ns
`include "lsu_consts.svh"
interface lsu_if;
  import lsu_pkg::*;
  logic big;
  size_t ld_size;
  logic [2:0] ld_off;
  logic [`LSU_DATA_W-1:0] ld_raw;
  logic [`LSU_DATA_W-1:0] ld_val;
  size_t st_size;
  logic [2:0] st_off;
  logic [`LSU_DATA_W-1:0] st_val;
  logic [`LSU_DATA_W-1:0] st_lanes;
  logic [`LSU_LANES-1:0] st_be;
  logic [`LSU_ADDR_W-1:0] cr_addr;
  size_t cr_size;
  logic cr_write;
  logic cr_super;
  logic cr_is_space;
  logic cr_unmapped;
  logic cr_perm_fault;
  modport ord_user(output big, ld_size, ld_off, ld_raw, st_size, st_off, st_val,
                   input ld_val, st_lanes, st_be);
  modport ord_unit(input big, ld_size, ld_off, ld_raw, st_size, st_off, st_val,
                   output ld_val, st_lanes, st_be);
  modport creg_user(output cr_addr, cr_size, cr_write, cr_super,
                    input cr_is_space, cr_unmapped, cr_perm_fault);
  modport creg_unit(input cr_addr, cr_size, cr_write, cr_super,
                    output cr_is_space, cr_unmapped, cr_perm_fault);
endinterface

// *** lsu_pkg.sv ***
// types shared by the load/store access checker modules
package lsu_pkg;
  typedef enum logic [1:0] {ACC_LOAD, ACC_DIS_LOAD, ACC_PREFETCH, ACC_STORE} access_t;
  typedef enum logic [2:0] {
    FAULT_NONE, FAULT_MISALIGN, FAULT_XLATE, FAULT_BUS, FAULT_CREG_UNMAPPED, FAULT_CREG_PERM
  } fault_t;
  // size code: 0 = 8, 1 = 16, 2 = 32, 3 = 64 bits
  typedef logic [1:0] size_t;
endpackage

// *** mem_model.sv ***
// memory subsystem stand-in answering reads after a chosen delay
`timescale 1ns/1ns
module mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the checker
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] paddr_i,
  // answer style set by the bench
  input wire logic [3:0] delay_i,
  input wire logic err_i,
  // read answer
  output logic rvalid_o,
  output logic rerr_o,
  output logic [63:0] rdata_o
);
  logic busy;
  logic [3:0] cnt;
  logic [31:0] pa;
  // one read in flight; idle data toggles so stale lanes never pass as valid
  always_ff @(posedge clk_i) begin
    rvalid_o <= 1'h0;
    rerr_o <= 1'h0;
    rdata_o <= ~rdata_o;
    if (rst_i) begin
      busy <= 1'h0;
      rdata_o <= '0;
    end else if (req_i && !we_i) begin
      busy <= 1'h1;
      cnt <= delay_i;
      pa <= paddr_i;
    end else if (busy && cnt < 4'h2) begin
      busy <= 1'h0;
      rvalid_o <= 1'h1;
      rerr_o <= err_i;
      for (int k = 0; k < 8; k++) begin
        rdata_o[8*k+:8] <= {pa[7:3], k[2:0]} ^ 8'ha5;
      end
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the load/store access checker
`timescale 1ns/1ns
module testbench;
  import lsu_pkg::*;
  localparam logic [31:0] X = 32'h01000000;
  localparam logic [4:0] OK = 5'h17;
  logic clk = 1'h0, rst = 1'h1, valid = 1'h0, bf = 1'h0, ton = 1'h1, sat = 1'h0;
  logic dyn = 1'h0, big = 1'h0, sup = 1'h1, m = 1'h0, mu = 1'h0, ro = 1'h0, wo = 1'h0;
  logic rg = 1'h0, dbon = 1'h0, err = 1'h0;
  access_t kind = ACC_LOAD;
  size_t size = 2'h0;
  logic [31:0] addr = '0, pa = '0, dlo = '0, dhi = '0;
  logic [63:0] wdata = '0;
  logic [3:0] dly = 4'h1;
  logic rdy, mreq, mwe, mcreg, rv, fv, pf, dbh, rvalid, rerr;
  logic [31:0] mpa, rd, fa, pfa;
  logic [63:0] mwd, rdata;
  logic [7:0] mbe;
  size_t msz, s_msz;
  fault_t fk;
  logic s_f, s_r, s_m, s_p, s_d, s_mwe, s_mc;
  fault_t s_fk;
  logic [31:0] s_fa, s_rd, s_mpa, s_pa;
  logic [7:0] s_mbe;
  logic [63:0] s_mwd;
  int n_mismatch = 0;
  int checks = 0;
  always #25 clk = ~clk;
  load_store_access_check DUT (
    .clk_i(clk), .rst_i(rst), .req_valid_i(valid), .req_kind_i(kind), .req_size_i(size),
    .req_addr_i(addr), .req_wdata_i(wdata), .bundle_fault_i(bf), .req_ready_o(rdy),
    .translation_on_i(ton), .spec_load_align_trap_on_i(sat), .dynamic_translation_on_i(dyn),
    .big_endian_i(big), .supervisor_i(sup), .tlb_match_i(m), .tlb_multi_i(mu),
    .tlb_read_ok_i(ro), .tlb_write_ok_i(wo), .tlb_paddr_i(pa),
    .system_control_unit_region_i(rg), .dbreak_on_i(dbon), .dbreak_lo_i(dlo),
    .dbreak_hi_i(dhi), .mem_req_o(mreq), .mem_we_o(mwe), .mem_creg_o(mcreg),
    .mem_paddr_o(mpa), .mem_size_o(msz), .mem_wdata_o(mwd), .mem_be_o(mbe),
    .mem_rvalid_i(rvalid), .mem_rerr_i(rerr), .mem_rdata_i(rdata), .resp_valid_o(rv),
    .resp_data_o(rd), .fault_valid_o(fv), .fault_kind_o(fk), .fault_addr_o(fa),
    .prefetch_o(pf), .prefetch_addr_o(pfa), .dbreak_hit_o(dbh));
  mem_model mem (.clk_i(clk), .rst_i(rst), .req_i(mreq), .we_i(mwe), .paddr_i(mpa),
    .delay_i(dly), .err_i(err), .rvalid_o(rvalid), .rerr_o(rerr), .rdata_o(rdata));
  // one-cycle pulses are latched here so scenarios can judge them afterwards
  always @(posedge clk) begin
    if (fv === 1'h1) begin
      s_f <= 1'h1;
      s_fk <= fk;
      s_fa <= fa;
    end
    if (rv === 1'h1) begin
      s_r <= 1'h1;
      s_rd <= rd;
    end
    if (mreq === 1'h1) begin
      {s_m, s_mwe, s_mc, s_mpa, s_mbe, s_mwd, s_msz} <= {1'h1, mwe, mcreg, mpa, mbe, mwd, msz};
    end
    if (pf === 1'h1) begin
      s_p <= 1'h1;
      s_pa <= pfa;
    end
    if (dbh === 1'h1) begin
      s_d <= 1'h1;
    end
  end
  ////////////////////////////////////////
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input bit c, input string msg);
    checks++;
    if (!c) begin
      n_mismatch++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  function automatic logic [7:0] pat(input logic [31:0] x);
    pat = x[7:0] ^ 8'ha5;
  endfunction
  // expected field: byte i from lane start+i, or start+n-1-i when big
  function automatic logic [31:0] ld_exp(input logic [31:0] p, input int n, input logic b);
    ld_exp = '0;
    for (int i = 0; i < n; i++) begin
      ld_exp[8*i+:8] = pat(p + 32'(b ? n - 1 - i : i));
    end
  endfunction
  // one request, held until taken, then wait a bounded time for its outcome
  task automatic op(input access_t k, input size_t s, input logic [31:0] a,
                    input logic [63:0] w, input logic [4:0] lk);
    int i;
    @(negedge clk);
    {s_f, s_r, s_m, s_p, s_d} = '0;
    @(posedge clk);
    valid <= 1'h1;
    kind <= k;
    size <= s;
    addr <= a;
    wdata <= w;
    {m, mu, ro, wo, rg} <= lk;
    pa <= a ^ X;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'h1 && i < 8);
    valid <= 1'h0;
    if (rdy !== 1'h1) begin
      n_mismatch++;
      $display("unexpected %0t request not taken", $time);
      final_report();
    end
    for (i = 0; i < 12 && !(s_f || s_r || s_p || (s_m && s_mwe === 1'h1)); i++) begin
      @(posedge clk);
    end
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_loads();
    logic [31:0] a;
    int n;
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 3; s++) begin
        n = 1 << s;
        a = 32'h20000040 | 32'(8 - n);
        @(posedge clk);
        big <= b[0];
        op(ACC_LOAD, s[1:0], a, '0, OK);
        chk(s_r && s_rd === ld_exp(a ^ X, n, b[0]), "load data");
        chk(s_mpa === (a ^ X) && !s_f, "load paddr");
      end
    end
  endtask
  task automatic t_fault();
    logic [4:0] bad [3] = '{5'h07, 5'h1f, 5'h13};
    op(ACC_LOAD, 2'h2, 32'h20000042, '0, 5'h00);
    chk(s_f && s_fk === FAULT_MISALIGN && s_fa === 32'h20000042 && !s_m, "ld align");
    op(ACC_STORE, 2'h1, 32'h20000041, '0, 5'h00);
    chk(s_f && s_fk === FAULT_MISALIGN && !s_m, "st align");
    foreach (bad[j]) begin
      op(ACC_LOAD, 2'h2, 32'h20000044, '0, bad[j]);
      chk(s_f && s_fk === FAULT_XLATE && s_fa === 32'h20000044 && !s_m, "ld xlate");
    end
    op(ACC_STORE, 2'h2, 32'h20000044, '0, 5'h15);
    chk(s_f && s_fk === FAULT_XLATE && !s_m, "st xlate");
    @(posedge clk);
    ton <= 1'h0;
    op(ACC_LOAD, 2'h2, 32'h20000044, '0, 5'h07);
    chk(s_r && !s_f, "xlate off");
    op(ACC_DIS_LOAD, 2'h2, 32'h20000042, '0, 5'h07);
    chk(s_r && s_rd === 32'h0 && !s_f && !s_m, "dis xlate off");
    @(posedge clk);
    {ton, dly, err} <= {1'h1, 4'h4, 1'h1};
    op(ACC_LOAD, 2'h1, 32'h20000046, '0, OK);
    chk(s_f && s_fk === FAULT_BUS && s_fa === 32'h20000046 && !s_r, "bus");
    op(ACC_DIS_LOAD, 2'h1, 32'h20000046, '0, OK);
    chk(s_f && s_fk === FAULT_BUS, "dis bus");
    @(posedge clk);
    {dly, err} <= {4'h1, 1'h0};
  endtask
  task automatic dis(input logic st, input logic dy, input logic [31:0] a,
                     input logic [4:0] lk, input fault_t f, input logic z);
    @(posedge clk);
    {sat, dyn} <= {st, dy};
    op(ACC_DIS_LOAD, 2'h2, a, '0, lk);
    if (f != FAULT_NONE) begin
      chk(s_f && s_fk === f && !s_r, "dis fault");
    end else begin
      chk(s_r && !s_f && s_rd === (z ? 32'h0 : ld_exp(a ^ X, 4, big)), "dis data");
    end
  endtask
  task automatic t_dis();
    dis(1'h0, 1'h0, 32'h20000042, OK, FAULT_NONE, 1'h1);
    dis(1'h1, 1'h0, 32'h20000042, OK, FAULT_MISALIGN, 1'h0);
    dis(1'h0, 1'h0, 32'h20000044, 5'h07, FAULT_NONE, 1'h1);
    dis(1'h0, 1'h1, 32'h20000044, 5'h07, FAULT_XLATE, 1'h0);
    dis(1'h0, 1'h0, 32'h20000044, 5'h1f, FAULT_XLATE, 1'h0);
    dis(1'h0, 1'h0, 32'h20000044, 5'h13, FAULT_NONE, 1'h1);
    dis(1'h0, 1'h0, 32'h20000044, 5'h16, FAULT_NONE, 1'h1);
    dis(1'h0, 1'h0, 32'h20000044, OK, FAULT_NONE, 1'h0);
    op(ACC_PREFETCH, 2'h2, 32'h20000044, '0, OK);
    chk(s_p && s_pa === 32'h20000044 && !s_f, "prefetch");
    op(ACC_PREFETCH, 2'h2, 32'h20000042, '0, 5'h16);
    chk(!s_p && !s_f, "prefetch out");
  endtask
  task automatic t_store();
    @(posedge clk);
    big <= 1'h0;
    op(ACC_STORE, 2'h3, 32'h30000008, 64'h0123456789abcdef, OK);
    chk(s_mwe === 1'h1 && s_mbe === 8'hff && s_mwd === 64'h0123456789abcdef, "st64");
    op(ACC_STORE, 2'h0, 32'h30000005, 64'h11111111111111ab, OK);
    chk(s_mbe === 8'h20 && s_mwd[47:40] === 8'hab && s_mpa === 32'h31000005, "st8");
    @(posedge clk);
    big <= 1'h1;
    op(ACC_STORE, 2'h1, 32'h30000002, 64'hffffffffffff1234, OK);
    chk(s_mbe === 8'h0c && s_mwd[31:16] === 16'h3412 && s_msz === 2'h1, "st big");
    @(posedge clk);
    bf <= 1'h1;
    op(ACC_STORE, 2'h2, 32'h30000004, '0, OK);
    chk(!s_m && !s_f, "bundle st");
    op(ACC_LOAD, 2'h2, 32'h30000004, '0, OK);
    chk(!s_m && !s_r, "bundle ld");
    @(posedge clk);
    {bf, sup} <= {1'h0, 1'h0};
    op(ACC_LOAD, 2'h2, 32'hffff0004, '0, 5'h00);
    chk(s_mc === 1'h1 && s_mpa === 32'hffff0004 && s_r && !s_f, "creg rd");
    op(ACC_LOAD, 2'h2, 32'hffff0100, '0, 5'h00);
    chk(s_f && s_fk === FAULT_CREG_UNMAPPED && !s_m, "creg undef");
    op(ACC_LOAD, 2'h0, 32'hffff0004, '0, 5'h00);
    chk(s_f && s_fk === FAULT_CREG_UNMAPPED, "creg byte");
    op(ACC_STORE, 2'h2, 32'hffff0004, '0, 5'h00);
    chk(s_f && s_fk === FAULT_CREG_PERM && !s_m, "creg perm");
    @(posedge clk);
    {sup, dbon, dlo, dhi} <= {1'h1, 1'h1, 32'h20000040, 32'h20000047};
    op(ACC_STORE, 2'h2, 32'hffff0004, '0, 5'h00);
    chk(s_mc === 1'h1 && !s_f, "creg wr");
    op(ACC_LOAD, 2'h2, 32'h20000044, '0, OK);
    chk(s_d, "break hit");
    op(ACC_LOAD, 2'h2, 32'h20000048, '0, OK);
    chk(!s_d, "break miss");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_loads();
    t_fault();
    t_dis();
    t_store();
    final_report();
  end
endmodule
